// *** hdl/iprcfg_pkg.sv ***
/*
 * Package for the upper priority configuration bank: register indices,
 * field positions, reset values and the carrier struct for the priority levels.
 * Assumes a 16-bit register port with one-cycle read latency.
 */
package iprcfg_pkg;

	// ----------------------------------------
	// Register indices (word addresses)
	// ----------------------------------------
	localparam logic [3:0] UART2_AND_EXT2_PRIORITY_IDX = 4'h0;
	localparam logic [3:0] TIMER3_GATE_PRIORITY_IDX = 4'h1;
	localparam logic [3:0] SERIAL_PORT2_PRIORITY_IDX = 4'h2;
	localparam logic [3:0] UART_ERROR_PRIORITY_IDX = 4'h3;
	localparam logic [3:0] VOLTAGE_DETECT_PRIORITY_IDX = 4'h4;
	localparam logic [3:0] WAKEUP_PRIORITY_IDX = 4'h5;

	// ----------------------------------------
	// Field positions (low bit of each 3-bit field)
	// ----------------------------------------
	localparam int FLD_HI = 12;
	localparam int FLD_MID = 8;
	localparam int FLD_LO = 4;
	localparam int FLD_BASE = 0;

	// ----------------------------------------
	// Values
	// ----------------------------------------
	localparam logic [2:0] PRIO_RESET = 3'h4;
	localparam logic [2:0] PRIO_DISABLED = 3'h0;
	localparam logic [15:0] READ_ZERO = 16'h0000;

	typedef logic [2:0] iprcfg_level_t;

	// All ten source levels, as they leave for the arbiter
	typedef struct packed {
		iprcfg_level_t uart2_tx_prio;
		iprcfg_level_t uart2_rx_prio;
		iprcfg_level_t ext_irq2_prio;
		iprcfg_level_t timer3_gate_prio;
		iprcfg_level_t port2_collision_prio;
		iprcfg_level_t port2_event_prio;
		iprcfg_level_t uart2_err_prio;
		iprcfg_level_t uart1_err_prio;
		iprcfg_level_t volt_detect_prio;
		iprcfg_level_t lowpower_wake_prio;
	} iprcfg_levels_s;

endpackage

// *** hdl/iprcfg_top.sv ***
/*
 * Upper priority configuration bank of the interrupt controller: ten 3-bit
 * priority fields, their register port, and per-source level and enable outputs.
 * Assumes the register master sits on SYS_CLK and never overlaps strobes.
 */
`timescale 1ns/1ps

// Summary of operation
// - Each 3-bit field is a level, 7 for all ones highest down to 1 lowest.
// - A field of zero disables its source so it never requests.
// - Unimplemented bits and unmapped addresses read as zero.
// - Every field resets to binary 100, level 4.
// - Register 0 holds UART2 transmit in 14-12, receive in 10-8, external 2 in 6-4.
// - Register 1 holds the timer 3 gate field in 6-4 only.
// - Register 2 holds port 2 collision in 10-8 and port 2 event in 6-4.
// - Register 3 holds UART2 error in 10-8 and UART1 error in 6-4.
// - Register 4 holds the voltage detect field in 2-0 only.
// - Register 5 holds the low-power wake field in its three lowest bits.
// - Every field is readable and writable and returns the last value written.
module iprcfg_top (
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic [3:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	output iprcfg_pkg::iprcfg_levels_s PRIO_LEVELS,
	output logic [9:0] SRC_ENABLED
);

	// ----------------------------------------
	// Strobe decode
	// ----------------------------------------
	// One select per register; an unmapped index selects nothing
	logic [5:0] addr_sel;
	logic [5:0] wr_sel;
	logic [5:0] rd_sel;

	always_comb begin
		addr_sel = 6'h00;
		case (REG_ADDR)
			iprcfg_pkg::UART2_AND_EXT2_PRIORITY_IDX: begin
				addr_sel[0] = 1'h1;
			end
			iprcfg_pkg::TIMER3_GATE_PRIORITY_IDX: begin
				addr_sel[1] = 1'h1;
			end
			iprcfg_pkg::SERIAL_PORT2_PRIORITY_IDX: begin
				addr_sel[2] = 1'h1;
			end
			iprcfg_pkg::UART_ERROR_PRIORITY_IDX: begin
				addr_sel[3] = 1'h1;
			end
			iprcfg_pkg::VOLTAGE_DETECT_PRIORITY_IDX: begin
				addr_sel[4] = 1'h1;
			end
			iprcfg_pkg::WAKEUP_PRIORITY_IDX: begin
				addr_sel[5] = 1'h1;
			end
			default: begin
			end
		endcase
	end

	// A write to an unmapped index has no select, so it changes nothing
	assign wr_sel = REG_WR ? addr_sel : 6'h00;
	assign rd_sel = REG_RD ? addr_sel : 6'h00;

	// ----------------------------------------
	// Register 0: UART2 transmit, UART2 receive, external 2
	// ----------------------------------------
	iprcfg_pkg::iprcfg_level_t uart2_tx_prio_q, uart2_tx_prio_d;
	iprcfg_pkg::iprcfg_level_t uart2_rx_prio_q, uart2_rx_prio_d;
	iprcfg_pkg::iprcfg_level_t ext_irq2_prio_q, ext_irq2_prio_d;

	always_comb begin
		uart2_tx_prio_d = uart2_tx_prio_q;
		uart2_rx_prio_d = uart2_rx_prio_q;
		ext_irq2_prio_d = ext_irq2_prio_q;
		// Bits without storage are simply not taken, so they stay zero
		if (wr_sel[0]) begin
			uart2_tx_prio_d = REG_WDATA[iprcfg_pkg::FLD_HI +: 3];
			uart2_rx_prio_d = REG_WDATA[iprcfg_pkg::FLD_MID +: 3];
			ext_irq2_prio_d = REG_WDATA[iprcfg_pkg::FLD_LO +: 3];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			uart2_tx_prio_q <= iprcfg_pkg::PRIO_RESET;
			uart2_rx_prio_q <= iprcfg_pkg::PRIO_RESET;
			ext_irq2_prio_q <= iprcfg_pkg::PRIO_RESET;
		end else begin
			uart2_tx_prio_q <= uart2_tx_prio_d;
			uart2_rx_prio_q <= uart2_rx_prio_d;
			ext_irq2_prio_q <= ext_irq2_prio_d;
		end
	end

	// ----------------------------------------
	// Register 1: timer 3 gate
	// ----------------------------------------
	iprcfg_pkg::iprcfg_level_t timer3_gate_prio_q, timer3_gate_prio_d;

	always_comb begin
		timer3_gate_prio_d = timer3_gate_prio_q;
		if (wr_sel[1]) begin
			timer3_gate_prio_d = REG_WDATA[iprcfg_pkg::FLD_LO +: 3];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			timer3_gate_prio_q <= iprcfg_pkg::PRIO_RESET;
		end else begin
			timer3_gate_prio_q <= timer3_gate_prio_d;
		end
	end

	// ----------------------------------------
	// Register 2: serial port 2 collision and event
	// ----------------------------------------
	iprcfg_pkg::iprcfg_level_t port2_collision_prio_q, port2_collision_prio_d;
	iprcfg_pkg::iprcfg_level_t port2_event_prio_q, port2_event_prio_d;

	always_comb begin
		port2_collision_prio_d = port2_collision_prio_q;
		port2_event_prio_d = port2_event_prio_q;
		if (wr_sel[2]) begin
			port2_collision_prio_d = REG_WDATA[iprcfg_pkg::FLD_MID +: 3];
			port2_event_prio_d = REG_WDATA[iprcfg_pkg::FLD_LO +: 3];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			port2_collision_prio_q <= iprcfg_pkg::PRIO_RESET;
			port2_event_prio_q <= iprcfg_pkg::PRIO_RESET;
		end else begin
			port2_collision_prio_q <= port2_collision_prio_d;
			port2_event_prio_q <= port2_event_prio_d;
		end
	end

	// ----------------------------------------
	// Register 3: UART error sources
	// ----------------------------------------
	iprcfg_pkg::iprcfg_level_t uart2_err_prio_q, uart2_err_prio_d;
	iprcfg_pkg::iprcfg_level_t uart1_err_prio_q, uart1_err_prio_d;

	always_comb begin
		uart2_err_prio_d = uart2_err_prio_q;
		uart1_err_prio_d = uart1_err_prio_q;
		if (wr_sel[3]) begin
			uart2_err_prio_d = REG_WDATA[iprcfg_pkg::FLD_MID +: 3];
			uart1_err_prio_d = REG_WDATA[iprcfg_pkg::FLD_LO +: 3];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			uart2_err_prio_q <= iprcfg_pkg::PRIO_RESET;
			uart1_err_prio_q <= iprcfg_pkg::PRIO_RESET;
		end else begin
			uart2_err_prio_q <= uart2_err_prio_d;
			uart1_err_prio_q <= uart1_err_prio_d;
		end
	end

	// ----------------------------------------
	// Register 4: voltage detect
	// ----------------------------------------
	iprcfg_pkg::iprcfg_level_t volt_detect_prio_q, volt_detect_prio_d;

	always_comb begin
		volt_detect_prio_d = volt_detect_prio_q;
		if (wr_sel[4]) begin
			volt_detect_prio_d = REG_WDATA[iprcfg_pkg::FLD_BASE +: 3];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			volt_detect_prio_q <= iprcfg_pkg::PRIO_RESET;
		end else begin
			volt_detect_prio_q <= volt_detect_prio_d;
		end
	end

	// ----------------------------------------
	// Register 5: low-power wake
	// ----------------------------------------
	iprcfg_pkg::iprcfg_level_t lowpower_wake_prio_q, lowpower_wake_prio_d;

	always_comb begin
		lowpower_wake_prio_d = lowpower_wake_prio_q;
		// Kept in the three lowest bits; software must not expect it at 6-4
		if (wr_sel[5]) begin
			lowpower_wake_prio_d = REG_WDATA[iprcfg_pkg::FLD_BASE +: 3];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			lowpower_wake_prio_q <= iprcfg_pkg::PRIO_RESET;
		end else begin
			lowpower_wake_prio_q <= lowpower_wake_prio_d;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Each image holds zeros wherever a bit has no storage
	logic [15:0] img [6];
	logic [15:0] rd_word;
	logic [15:0] rdata_q, rdata_d;

	always_comb begin
		for (int r = 0; r < 6; r++) begin
			img[r] = iprcfg_pkg::READ_ZERO;
		end
		img[0][iprcfg_pkg::FLD_HI +: 3] = uart2_tx_prio_q;
		img[0][iprcfg_pkg::FLD_MID +: 3] = uart2_rx_prio_q;
		img[0][iprcfg_pkg::FLD_LO +: 3] = ext_irq2_prio_q;
		img[1][iprcfg_pkg::FLD_LO +: 3] = timer3_gate_prio_q;
		img[2][iprcfg_pkg::FLD_MID +: 3] = port2_collision_prio_q;
		img[2][iprcfg_pkg::FLD_LO +: 3] = port2_event_prio_q;
		img[3][iprcfg_pkg::FLD_MID +: 3] = uart2_err_prio_q;
		img[3][iprcfg_pkg::FLD_LO +: 3] = uart1_err_prio_q;
		img[4][iprcfg_pkg::FLD_BASE +: 3] = volt_detect_prio_q;
		img[5][iprcfg_pkg::FLD_BASE +: 3] = lowpower_wake_prio_q;
	end

	// Zero outside a read cycle, so a stale word never lingers on the bus
	always_comb begin
		rd_word = iprcfg_pkg::READ_ZERO;
		for (int r = 0; r < 6; r++) begin
			if (rd_sel[r]) begin
				rd_word = img[r];
			end
		end
		rdata_d = rd_word;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			rdata_q <= iprcfg_pkg::READ_ZERO;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------
	// Source enables
	// ----------------------------------------
	// Taken from the next field values so each enable lines up with its level
	iprcfg_pkg::iprcfg_levels_s levels_q;
	iprcfg_pkg::iprcfg_levels_s levels_d;
	logic [9:0] enabled_q, enabled_d;

	assign levels_q = {uart2_tx_prio_q, uart2_rx_prio_q, ext_irq2_prio_q,
		timer3_gate_prio_q, port2_collision_prio_q, port2_event_prio_q,
		uart2_err_prio_q, uart1_err_prio_q, volt_detect_prio_q,
		lowpower_wake_prio_q};

	assign levels_d = {uart2_tx_prio_d, uart2_rx_prio_d, ext_irq2_prio_d,
		timer3_gate_prio_d, port2_collision_prio_d, port2_event_prio_d,
		uart2_err_prio_d, uart1_err_prio_d, volt_detect_prio_d,
		lowpower_wake_prio_d};

	// Level 1 is the lowest that still requests; zero is the only off code
	genvar g;
	generate
		for (g = 0; g < 10; g++) begin : g_enable
			assign enabled_d[g] = (levels_d[g*3 +: 3] != iprcfg_pkg::PRIO_DISABLED);
		end
	endgenerate

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			enabled_q <= '1;
		end else begin
			enabled_q <= enabled_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign REG_RDATA = rdata_q;
	assign PRIO_LEVELS = levels_q;
	assign SRC_ENABLED = enabled_q;

endmodule // iprcfg_top

// *** testbench/iprcfg_checker.sv ***
/* Port checker for iprcfg_top.
   Assumes it is bound into the top; one clock domain. */
`timescale 1ns/1ps
module iprcfg_checker (
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic [3:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_RDATA,
	input wire iprcfg_pkg::iprcfg_levels_s PRIO_LEVELS,
	input wire logic [9:0] SRC_ENABLED
);
	// --------
	// Properties
	// --------
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	a_rd_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0) else $error("rd");
	a_wr_tx: assert property (REG_WR && REG_ADDR == 4'h0 |=>
		PRIO_LEVELS[29:27] == $past(REG_WDATA[14:12])) else $error("tx");
	a_wr_gate: assert property (REG_WR && REG_ADDR == 4'h1 |=>
		PRIO_LEVELS[20:18] == $past(REG_WDATA[6:4])) else $error("gate");
	a_wr_coll: assert property (REG_WR && REG_ADDR == 4'h2 |=>
		PRIO_LEVELS[17:15] == $past(REG_WDATA[10:8])) else $error("coll");
	a_wr_err: assert property (REG_WR && REG_ADDR == 4'h3 |=>
		PRIO_LEVELS[8:6] == $past(REG_WDATA[6:4])) else $error("err");
	a_rd_volt: assert property (REG_RD && REG_ADDR == 4'h4 |=>
		REG_RDATA == {13'h0, $past(PRIO_LEVELS[5:3])}) else $error("volt");
	a_wr_wake: assert property (REG_WR && REG_ADDR == 4'h5 |=>
		PRIO_LEVELS[2:0] == $past(REG_WDATA[2:0])) else $error("wake");
	a_en_zero: assert property (SRC_ENABLED[0] == (PRIO_LEVELS[2:0] != 3'h0)) else $error("en");
endmodule // iprcfg_checker

// *** testbench/iprcfg_top_tb.sv ***
/* Bench for the priority bank: random and corner register traffic.
   Assumes the package, iprcfg_top and the checker are compiled first. */
`timescale 1ns/1ps
module iprcfg_top_tb;
	// --------
	// Stimulus
	// --------
	logic SYS_CLK = 0, RESET = 1, REG_WR = 0, REG_RD = 0;
	logic [3:0] REG_ADDR = 4'h0;
	logic [15:0] REG_WDATA = 16'h0, REG_RDATA, m[8];
	logic [15:0] mk[8] = '{16'h7770, 16'h0070, 16'h0770, 16'h0770, 16'h0007, 16'h0007, 16'h0, 16'h0};
	iprcfg_pkg::iprcfg_levels_s PRIO_LEVELS;
	logic [29:0] lv;
	logic [9:0] SRC_ENABLED, en;
	int n_errors = 0, n_checks = 0, ra;
	always #2 SYS_CLK = ~SYS_CLK;
	iprcfg_top i_iprcfg_top (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.PRIO_LEVELS(PRIO_LEVELS), .SRC_ENABLED(SRC_ENABLED));
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Reset restores every field to level 4 in the model
	task automatic rst(int n);
		@(posedge SYS_CLK);
		RESET <= 1'h1;
		repeat (n) @(posedge SYS_CLK);
		RESET <= 1'h0;
		for (int a = 0; a < 8; a++) m[a] = 16'h4444 & mk[a];
	endtask
	task automatic wr(int a, logic [15:0] d);
		@(posedge SYS_CLK);
		REG_WR <= 1'h1;
		REG_ADDR <= a[3:0];
		REG_WDATA <= d;
		@(posedge SYS_CLK);
		REG_WR <= 1'h0;
		m[a] = d & mk[a];
	endtask
	// Read back, then compare the level and enable outputs too
	task automatic rd(int a);
		@(posedge SYS_CLK);
		REG_RD <= 1'h1;
		REG_ADDR <= a[3:0];
		@(posedge SYS_CLK);
		REG_RD <= 1'h0;
		#1 chk(REG_RDATA, m[a]);
		lv = {m[0][14:12], m[0][10:8], m[0][6:4], m[1][6:4], m[2][10:8], m[2][6:4],
			m[3][10:8], m[3][6:4], m[4][2:0], m[5][2:0]};
		for (int i = 0; i < 10; i++) en[i] = |lv[i*3 +: 3];
		chk(PRIO_LEVELS, lv);
		chk(SRC_ENABLED, en);
	endtask
	initial begin
		void'($urandom(69));
		rst(4);
		for (int a = 0; a < 8; a++) rd(a);
		repeat (80) begin
			ra = $urandom % 8;
			wr(ra, ($urandom % 3 == 0) ? {16{ra[0]}} : 16'($urandom));
			rd(ra);
		end
		rst(1);
		for (int a = 0; a < 8; a++) rd(a);
		print_verdict;
	end
	initial begin
		#20000;
		n_errors++;
		print_verdict;
	end
endmodule // iprcfg_top_tb
bind iprcfg_top iprcfg_checker i_iprcfg_checker (.SYS_CLK(SYS_CLK), .RESET(RESET),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .PRIO_LEVELS(PRIO_LEVELS), .SRC_ENABLED(SRC_ENABLED));
